// file: tmc_pkg.sv
`default_nettype none
package tmc_pkg;

   // register map, byte addresses
   localparam int TMC_AW = 8;
   localparam logic [TMC_AW-1:0] TMC_ADDR_CTRL = 8'h10;
   localparam logic [TMC_AW-1:0] TMC_ADDR_CNT_LO = 8'h14;
   localparam logic [TMC_AW-1:0] TMC_ADDR_CNT_HI = 8'h18;
   localparam logic [TMC_AW-1:0] TMC_ADDR_FLAG = 8'h1c;
   localparam logic [TMC_AW-1:0] TMC_ADDR_IEN = 8'h20;

   // field positions and widths
   localparam int TMC_CTRL_W = 6;
   localparam int TMC_OVF_BIT = 0;
   localparam int TMC_BYTE_W = 8;
   localparam int TMC_CNT_W = 16;
   localparam logic [TMC_CTRL_W-1:0] TMC_CTRL_RESET = 6'h00;
   localparam logic [TMC_CNT_W-1:0] TMC_CNT_MAX = 16'hffff;
   localparam logic [TMC_CNT_W-1:0] TMC_CNT_ZERO = 16'h0000;

   // axi responses
   localparam logic [1:0] TMC_RESP_OKAY = 2'h0;
   localparam logic [1:0] TMC_RESP_SLVERR = 2'h2;

   // timing: instruction cycle is four system clocks
   localparam int TMC_CLK_PERIOD_NS = 5;
   localparam int TMC_INSTR_NS = 20;
   localparam logic [1:0] TMC_PHASE_LAST = 2'((TMC_INSTR_NS / TMC_CLK_PERIOD_NS) - 1);

   typedef struct packed {
      logic [1:0] prescale_select;
      logic crystal_osc_enable;
      logic sync_bypass;
      logic count_source_select;
      logic counter_on;
   } tmc_ctrl_t;

   typedef enum logic [1:0] {
      TMC_MODE_STOP = 2'b00,
      TMC_MODE_TIMER = 2'b01,
      TMC_MODE_SYNC = 2'b10,
      TMC_MODE_ASYNC = 2'b11
   } tmc_mode_t;

   function automatic logic [2:0] tmc_prescale_mask(input logic [1:0] sel);
      case (sel)
         2'b00: tmc_prescale_mask = 3'h0;
         2'b01: tmc_prescale_mask = 3'h1;
         2'b10: tmc_prescale_mask = 3'h3;
         default: tmc_prescale_mask = 3'h7;
      endcase
   endfunction : tmc_prescale_mask

   function automatic tmc_mode_t tmc_mode_of(input tmc_ctrl_t c);
      if (!c.counter_on) begin
         tmc_mode_of = TMC_MODE_STOP;
      end else if (!c.count_source_select) begin
         tmc_mode_of = TMC_MODE_TIMER;
      end else if (c.sync_bypass) begin
         tmc_mode_of = TMC_MODE_ASYNC;
      end else begin
         tmc_mode_of = TMC_MODE_SYNC;
      end
   endfunction : tmc_mode_of

endpackage : tmc_pkg
`default_nettype wire

// file: tmc_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tmc_prescaler
   import tmc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic clear,
   input wire logic [1:0] prescale_select,
   // source and output
   input wire logic tick_in,
   output logic tick_out
);

   logic [2:0] cnt_reg;
   logic [2:0] mask;

   assign mask = tmc_prescale_mask(prescale_select);

   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         cnt_reg <= 3'h0;
      end else if (tick_in) begin
         if ((cnt_reg & mask) == mask) begin
            cnt_reg <= 3'h0;
         end else begin
            cnt_reg <= cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= tick_in && ((cnt_reg & mask) == mask);
      end
   end

endmodule : tmc_prescaler
`default_nettype wire

// file: tmc_edge_gate.sv
`timescale 1ns/100ps
`default_nettype none
module tmc_edge_gate
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // counter mode not active
   input wire logic disarm,
   // selected count pin
   input wire logic pin,
   // gated rising edge
   output logic rise,
   output logic armed
);

   logic pin_reg;
   logic prev_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         pin_reg <= pin;
         prev_reg <= pin_reg;
      end
   end

   // a falling edge must be seen before any rising edge counts
   always_ff @(posedge aclk) begin
      if (!aresetn || disarm) begin
         armed <= 1'b0;
      end else if (prev_reg && !pin_reg) begin
         armed <= 1'b1;
      end
   end

   assign rise = armed && pin_reg && !prev_reg;

endmodule : tmc_edge_gate
`default_nettype wire

// file: tmc_timer.sv
// Function
// - sixteen bit count wraps from max to zero
// - wrap sets overflow flag, enable gates interrupt
// - source select picks pin edges or instruction clock
// - timer mode steps once per instruction cycle
// - counter on bit starts, clear holds count
// - two bit prescale divides by 1,2,4,8
// - oscillator enable bit powers crystal oscillator
// - sync bypass bit skips synchronizer in counter mode
// - control bits seven and six read zero
// - falling edge needed before first counted rise
// - oscillator enable picks oscillator or clock pin
// - oscillator on forces pins input
// - synchronizer sits after prescaler, not before
// - sync counter mode halts count in sleep
// - async counter runs in sleep, overflow wakes
// - async count is no capture/compare time base
// - byte reads return valid value while running
// - capture/compare units can reset the count
// - control clears only on power-on reset
// - count halves cleared only by special event
// - count write clears prescaler, beats special event
`timescale 1ns/100ps
`default_nettype none
module tmc_timer
   import tmc_pkg::*;
(
   // clock and power-on reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [TMC_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [TMC_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // count pins and system
   input wire logic external_count_pin,
   input wire logic osc_input_pin,
   input wire logic sleep_req,
   input wire logic ccp1_special_event,
   input wire logic ccp2_special_event,
   // outputs
   output logic overflow_irq,
   output logic wake_req,
   output logic osc_amp_enable,
   output logic osc_pins_as_inputs,
   output logic ccp_timebase_valid,
   output logic [TMC_CNT_W-1:0] ccp_timebase
);

   tmc_ctrl_t ctrl_reg;
   tmc_mode_t mode;
   logic [TMC_CNT_W-1:0] count_reg;
   logic overflow_flag_reg;
   logic overflow_irq_enable_reg;
   logic [1:0] phase_reg;
   logic counter_mode_reg;
   logic [TMC_AW-1:0] aw_addr_reg;
   logic [TMC_AW-1:0] ar_addr_reg;
   logic [7:0] wbyte_reg;
   logic wbyte_en_reg;
   logic commit;
   logic wr_ctrl, wr_lo, wr_hi, wr_flag, wr_ien, wr_hit;
   logic instr_tick, src_tick, pre_tick, edge_rise, edge_armed, count_pin;
   logic sync_a_reg, sync_b_reg;
   logic inc, special_event, ovf_evt, write_count;

   assign mode = tmc_mode_of(ctrl_reg);

   // ---------------- axi4-lite write side ----------------
   assign commit = !awready && !wready && !bvalid;
   assign wr_hit = (aw_addr_reg == TMC_ADDR_CTRL) || (aw_addr_reg == TMC_ADDR_CNT_LO) ||
                   (aw_addr_reg == TMC_ADDR_CNT_HI) || (aw_addr_reg == TMC_ADDR_FLAG) ||
                   (aw_addr_reg == TMC_ADDR_IEN);
   assign wr_ctrl = commit && wbyte_en_reg && (aw_addr_reg == TMC_ADDR_CTRL);
   assign wr_lo = commit && wbyte_en_reg && (aw_addr_reg == TMC_ADDR_CNT_LO);
   assign wr_hi = commit && wbyte_en_reg && (aw_addr_reg == TMC_ADDR_CNT_HI);
   assign wr_flag = commit && wbyte_en_reg && (aw_addr_reg == TMC_ADDR_FLAG);
   assign wr_ien = commit && wbyte_en_reg && (aw_addr_reg == TMC_ADDR_IEN);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         aw_addr_reg <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_addr_reg <= {awaddr[TMC_AW-1:2], 2'b00};
      end else if (bvalid && bready) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b1;
         wbyte_reg <= 8'h00;
         wbyte_en_reg <= 1'b0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         wbyte_reg <= wdata[7:0];
         wbyte_en_reg <= wstrb[0];
      end else if (bvalid && bready) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= TMC_RESP_OKAY;
      end else if (commit) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // ---------------- axi4-lite read side ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= TMC_RESP_OKAY;
         ar_addr_reg <= '0;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         ar_addr_reg <= {araddr[TMC_AW-1:2], 2'b00};
         rresp <= TMC_RESP_OKAY;
         case ({araddr[TMC_AW-1:2], 2'b00})
            TMC_ADDR_CTRL: rdata <= {26'h0, ctrl_reg};
            TMC_ADDR_CNT_LO: rdata <= {24'h0, count_reg[7:0]};
            TMC_ADDR_CNT_HI: rdata <= {24'h0, count_reg[15:8]};
            TMC_ADDR_FLAG: rdata <= {31'h0, overflow_flag_reg};
            TMC_ADDR_IEN: rdata <= {31'h0, overflow_irq_enable_reg};
            default: begin
               rdata <= 32'h0;
               rresp <= TMC_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ---------------- control registers ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= TMC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= wbyte_reg[TMC_CTRL_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_irq_enable_reg <= 1'b0;
      end else if (wr_ien) begin
         overflow_irq_enable_reg <= wbyte_reg[TMC_OVF_BIT];
      end
   end

   // ---------------- count source ----------------
   // instruction clock: one tick every fourth system clock, frozen in sleep
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_reg <= 2'h0;
      end else if (!sleep_req) begin
         phase_reg <= (phase_reg == TMC_PHASE_LAST) ? 2'h0 : phase_reg + 2'h1;
      end
   end
   assign instr_tick = !sleep_req && (phase_reg == TMC_PHASE_LAST);

   assign count_pin = ctrl_reg.crystal_osc_enable ? osc_input_pin : external_count_pin;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter_mode_reg <= 1'b0;
      end else begin
         counter_mode_reg <= ctrl_reg.counter_on && ctrl_reg.count_source_select;
      end
   end

   tmc_edge_gate u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .disarm(!counter_mode_reg),
      .pin(count_pin),
      .rise(edge_rise),
      .armed(edge_armed)
   );

   assign src_tick = ctrl_reg.counter_on &&
                     (ctrl_reg.count_source_select ? edge_rise : instr_tick);

   assign write_count = wr_lo || wr_hi;

   tmc_prescaler u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(write_count),
      .prescale_select(ctrl_reg.prescale_select),
      .tick_in(src_tick),
      .tick_out(pre_tick)
   );

   // synchronizer stage after the prescaler
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a_reg <= 1'b0;
         sync_b_reg <= 1'b0;
      end else begin
         sync_a_reg <= pre_tick;
         sync_b_reg <= sync_a_reg;
      end
   end

   always_comb begin
      case (mode)
         TMC_MODE_TIMER: inc = pre_tick;
         TMC_MODE_SYNC: inc = sync_b_reg && !sleep_req;
         TMC_MODE_ASYNC: inc = pre_tick;
         default: inc = 1'b0;
      endcase
   end

   // special event reset is not honoured in asynchronous counting
   assign special_event = (ccp1_special_event || ccp2_special_event) &&
                          (mode != TMC_MODE_ASYNC);

   assign ovf_evt = inc && !write_count && !special_event && (count_reg == TMC_CNT_MAX);

   // ---------------- count register, no device reset ----------------
   always_ff @(posedge aclk) begin
      if (wr_lo) begin
         count_reg[7:0] <= wbyte_reg;
      end else if (wr_hi) begin
         count_reg[15:8] <= wbyte_reg;
      end else if (special_event) begin
         count_reg <= TMC_CNT_ZERO;
      end else if (inc) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // overflow flag: set beats a simultaneous clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag_reg <= 1'b0;
      end else if (ovf_evt) begin
         overflow_flag_reg <= 1'b1;
      end else if (wr_flag && wbyte_reg[TMC_OVF_BIT]) begin
         overflow_flag_reg <= 1'b0;
      end
   end

   // ---------------- registered outputs ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_irq <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         overflow_irq <= overflow_flag_reg && overflow_irq_enable_reg;
         wake_req <= overflow_flag_reg && overflow_irq_enable_reg && sleep_req &&
                     (mode == TMC_MODE_ASYNC);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_amp_enable <= 1'b0;
         osc_pins_as_inputs <= 1'b0;
      end else begin
         osc_amp_enable <= ctrl_reg.crystal_osc_enable;
         osc_pins_as_inputs <= ctrl_reg.crystal_osc_enable;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ccp_timebase_valid <= 1'b0;
         ccp_timebase <= TMC_CNT_ZERO;
      end else begin
         ccp_timebase_valid <= (mode == TMC_MODE_TIMER) || (mode == TMC_MODE_SYNC);
         ccp_timebase <= count_reg;
      end
   end

   // ---------------- assertions ----------------
   property p_wrap;
      @(posedge aclk) disable iff (!aresetn)
      ovf_evt |=> (count_reg == TMC_CNT_ZERO) && overflow_flag_reg;
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

   property p_irq;
      @(posedge aclk) disable iff (!aresetn)
      (overflow_flag_reg && overflow_irq_enable_reg) |=> overflow_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_timer_rate;
      @(posedge aclk) disable iff (!aresetn)
      (mode == TMC_MODE_TIMER && inc) |=> !inc [*3];
   endproperty
   a_timer_rate: assert property (p_timer_rate) else $error("timer too fast");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
      (!ctrl_reg.counter_on && !write_count && !special_event) |=> $stable(count_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("stopped count moved");

   property p_rsvd;
      @(posedge aclk) disable iff (!aresetn)
      (rvalid && ar_addr_reg == TMC_ADDR_CTRL) |-> (rdata[31:6] == 26'h0);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

   property p_armed;
      @(posedge aclk) disable iff (!aresetn)
      $rose(counter_mode_reg) |-> !edge_armed;
   endproperty
   a_armed: assert property (p_armed) else $error("armed on counter entry");

   property p_sync_sleep;
      @(posedge aclk) disable iff (!aresetn)
      (sleep_req && mode == TMC_MODE_SYNC) |-> !inc;
   endproperty
   a_sync_sleep: assert property (p_sync_sleep) else $error("sync count in sleep");

   property p_timebase;
      @(posedge aclk) disable iff (!aresetn)
      (mode == TMC_MODE_ASYNC) |=> !ccp_timebase_valid;
   endproperty
   a_timebase: assert property (p_timebase) else $error("async used as time base");

   property p_write_wins;
      @(posedge aclk) disable iff (!aresetn)
      (wr_lo && special_event) |=> (count_reg[7:0] == $past(wbyte_reg));
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("write lost to event");

   property p_sticky;
      @(posedge aclk) disable iff (!aresetn)
      (overflow_flag_reg && !wr_flag) |=> overflow_flag_reg;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");

   c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) ovf_evt);
   c_wake: cover property (@(posedge aclk) disable iff (!aresetn) wake_req);
   c_event: cover property (@(posedge aclk) disable iff (!aresetn) special_event && inc);
   c_async: cover property (@(posedge aclk) disable iff (!aresetn)
      mode == TMC_MODE_ASYNC && inc);

endmodule : tmc_timer
`default_nettype wire

// file: tmc_pin_source.sv
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_source #(
   parameter int HOLD = 4,
   parameter int OSC_START = 20
) (
   // clock
   input wire logic aclk,
   // count pins
   output var logic ext_pin,
   output var logic osc_pin
);
   initial begin
      ext_pin = 1'b0;
      osc_pin = 1'b0;
   end

   // n pulses, each level held HOLD cycles, idle low
   task automatic pulses(input int n, input bit osc);
      if (osc) begin
         repeat (OSC_START) @(posedge aclk);
      end
      repeat (n) begin
         @(posedge aclk);
         if (osc) osc_pin <= 1'b1; else ext_pin <= 1'b1;
         repeat (HOLD) @(posedge aclk);
         if (osc) osc_pin <= 1'b0; else ext_pin <= 1'b0;
         repeat (HOLD - 1) @(posedge aclk);
      end
      repeat (2 * HOLD) @(posedge aclk);
   endtask : pulses
endmodule : tmc_pin_source
`default_nettype wire

// file: tmc_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_bench
   import tmc_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [TMC_AW-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0;
   logic [1:0] bresp, rresp;
   // special event held through reset clears the count, which no reset touches
   logic ext_pin, osc_pin, sleep_req = 1'b0, ccp1 = 1'b1, ccp2 = 1'b0;
   logic overflow_irq, wake_req, osc_amp_enable, osc_pins_as_inputs, tb_valid;
   logic [15:0] tb_cnt;
   int error_cnt = 0, checks = 0, cyc = 0;

   tmc_timer DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .external_count_pin(ext_pin), .osc_input_pin(osc_pin),
      .sleep_req(sleep_req), .ccp1_special_event(ccp1), .ccp2_special_event(ccp2),
      .overflow_irq(overflow_irq), .wake_req(wake_req), .osc_amp_enable(osc_amp_enable),
      .osc_pins_as_inputs(osc_pins_as_inputs), .ccp_timebase_valid(tb_valid),
      .ccp_timebase(tb_cnt));

   tmc_pin_source pins (.aclk(aclk), .ext_pin(ext_pin), .osc_pin(osc_pin));

   initial begin
      forever #2.5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [TMC_AW-1:0] a, input logic [31:0] d);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'h1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [TMC_AW-1:0] a, output logic [31:0] d);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
   endtask : rd

   task automatic get_cnt(output logic [15:0] c);
      logic [31:0] d;
      rd(TMC_ADDR_CNT_LO, d);
      c[7:0] = d[7:0];
      rd(TMC_ADDR_CNT_HI, d);
      c[15:8] = d[7:0];
   endtask : get_cnt

   task automatic set_cnt(input logic [15:0] v);
      wr(TMC_ADDR_CTRL, 32'h0);
      wr(TMC_ADDR_CNT_HI, {24'h0, v[15:8]});
      wr(TMC_ADDR_CNT_LO, {24'h0, v[7:0]});
   endtask : set_cnt

   task automatic near(input logic [15:0] c, input int e);
      chk(32'((c >= 16'(e - 1)) && (c <= 16'(e + 1))), 32'h1);
   endtask : near

   task automatic run_pins(input logic [15:0] s, input logic [31:0] ctl, input int n,
      input bit osc, output logic [15:0] c);
      set_cnt(s);
      wr(TMC_ADDR_CTRL, ctl);
      pins.pulses(n, osc);
      wr(TMC_ADDR_CTRL, 32'h0);
      get_cnt(c);
   endtask : run_pins

   task automatic t_regs();
      logic [31:0] d;
      wr(8'h24, 32'hff);
      chk(32'(bresp), 32'(TMC_RESP_SLVERR));
      rd(8'h24, d);
      chk(d, 32'h0);
      chk(32'(rresp), 32'(TMC_RESP_SLVERR));
      rd(TMC_ADDR_CTRL, d);
      chk(d, 32'h0);
      wr(TMC_ADDR_CTRL, 32'hff);
      rd(TMC_ADDR_CTRL, d);
      chk(d, 32'h3f);
      chk(32'(osc_amp_enable), 32'h1);
      chk(32'(osc_pins_as_inputs), 32'h1);
      wr(TMC_ADDR_CTRL, 32'h0);
      repeat (2) @(posedge aclk);
      chk(32'(osc_amp_enable), 32'h0);
   endtask : t_regs

   task automatic t_timer();
      logic [15:0] c, c2;
      for (int ps = 0; ps < 4; ps++) begin
         set_cnt(16'h0000);
         wr(TMC_ADDR_CTRL, 32'(ps << 4) | 32'h1);
         repeat (200) @(posedge aclk);
         chk(32'(tb_valid), 32'h1);
         repeat (200) @(posedge aclk);
         wr(TMC_ADDR_CTRL, 32'h0);
         get_cnt(c);
         near(c, 100 >> ps);
         repeat (50) @(posedge aclk);
         get_cnt(c2);
         chk(32'(c2), 32'(c));
      end
   endtask : t_timer

   task automatic t_wrap();
      logic [15:0] c;
      logic [31:0] d;
      set_cnt(16'hfffe);
      wr(TMC_ADDR_IEN, 32'h1);
      wr(TMC_ADDR_CTRL, 32'h1);
      repeat (40) @(posedge aclk);
      wr(TMC_ADDR_CTRL, 32'h0);
      get_cnt(c);
      chk(32'(c < 16'h0010), 32'h1);
      chk(32'(overflow_irq), 32'h1);
      wr(TMC_ADDR_IEN, 32'h0);
      repeat (2) @(posedge aclk);
      chk(32'(overflow_irq), 32'h0);
      rd(TMC_ADDR_FLAG, d);
      chk(d, 32'h1);
      wr(TMC_ADDR_FLAG, 32'h1);
      rd(TMC_ADDR_FLAG, d);
      chk(d, 32'h0);
   endtask : t_wrap

   task automatic t_count();
      logic [15:0] c;
      run_pins(16'h0, 32'h03, 5, 1'b0, c);
      chk(32'(c), 32'h4);
      run_pins(16'h0, 32'h17, 9, 1'b0, c);
      chk(32'(c), 32'h4);
      run_pins(16'h0, 32'h0b, 5, 1'b1, c);
      chk(32'(c), 32'h4);
      sleep_req <= 1'b1;
      run_pins(16'h0, 32'h03, 5, 1'b0, c);
      chk(32'(c), 32'h0);
      wr(TMC_ADDR_IEN, 32'h1);
      set_cnt(16'hfffc);
      wr(TMC_ADDR_CTRL, 32'h07);
      pins.pulses(5, 1'b0);
      chk(32'(wake_req), 32'h1);
      chk(32'(tb_valid), 32'h0);
      wr(TMC_ADDR_CTRL, 32'h0);
      get_cnt(c);
      chk(32'(c), 32'h0);
      sleep_req <= 1'b0;
   endtask : t_count

   task automatic t_ccp();
      logic [15:0] c;
      logic [31:0] d;
      for (int k = 0; k < 2; k++) begin
         set_cnt(16'h1234);
         wr(TMC_ADDR_CTRL, 32'h1);
         repeat (8) @(posedge aclk);
         ccp1 <= (k == 0);
         ccp2 <= (k == 1);
         @(posedge aclk);
         ccp1 <= 1'b0;
         ccp2 <= 1'b0;
         repeat (8) @(posedge aclk);
         wr(TMC_ADDR_CTRL, 32'h0);
         get_cnt(c);
         chk(32'(c < 16'h0008), 32'h1);
      end
      set_cnt(16'h0000);
      // low byte write meets a special event; the write must win
      fork
         wr(TMC_ADDR_CNT_LO, 32'ha5);
         begin
            repeat (2) @(posedge aclk);
            ccp1 <= 1'b1;
            @(posedge aclk);
            ccp1 <= 1'b0;
         end
      join
      wr(TMC_ADDR_CTRL, 32'h3e);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      get_cnt(c);
      chk(32'(c), 32'h00a5);
      chk(32'(tb_cnt), 32'h00a5);
      rd(TMC_ADDR_CTRL, d);
      chk(d, 32'h0);
   endtask : t_ccp

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      ccp1 <= 1'b0;
      t_regs();
      t_timer();
      t_wrap();
      t_count();
      t_ccp();
      give_verdict();
   end
endmodule : tmc_timer_bench
`default_nettype wire
